// ==== verilog/cae_cfg.svh ====
// Contract
// RULE1 - each alarm has configurable trip level and hysteresis in engineering units
// RULE2 - high alarm sets above trip, clears below trip minus hysteresis; low mirrors
// RULE3 - delayed alarm holds off for configured seconds after enable turns on
// RULE4 - after hold-off the delayed alarm behaves as ordinary high or low alarm
// RULE5 - high rate alarm activates when change exceeds deviation within period
// RULE6 - low rate alarm activates when change stays below deviation within period
// RULE7 - rate alarm stays active until rate in limits for one full period; code waits for two consecutive in-limit period ends
// RULE8 - source is averaged over filter time before rate evaluation
// RULE9 - alarm enabled only while selected source active; no source means always enabled
// RULE10 - with logging on, every alarm state change writes an event log entry
// RULE11 - optional acknowledge timeout, switchable, 1 to 999 minutes
// RULE12 - acknowledged alarm still in condition at timeout returns to unacknowledged
// RULE13 - alarm may belong to any combination of twelve groups
// RULE14 - each group output is OR of states of member alarms
//
// Purpose: offsets, fields, reset values and timing counts of the alarm evaluator
// Assumes: 50 MHz pclk, 32-bit APB
// Notes: values are signed 16-bit engineering units
`ifndef CAE_CFG_SVH
`define CAE_CFG_SVH
`define CAE_CLK_HZ 50000000
`define CAE_TICK_CYC (`CAE_CLK_HZ)
`define CAE_SEC_PER_MIN 60
`define CAE_ACK_MIN_LO 10'd1
`define CAE_ACK_MIN_HI 10'd999
`define CAE_OFF_CTRL 12'h000
`define CAE_OFF_TRIP 12'h004
`define CAE_OFF_HYST 12'h008
`define CAE_OFF_DELAY 12'h00c
`define CAE_OFF_DEV 12'h010
`define CAE_OFF_PERIOD 12'h014
`define CAE_OFF_FILT 12'h018
`define CAE_OFF_ACKTO 12'h01c
`define CAE_OFF_GROUP 12'h020
`define CAE_OFF_STATE 12'h024
`define CAE_OFF_IRQ_STAT 12'h028
`define CAE_OFF_IRQ_MASK 12'h02c
`define CAE_OFF_ACK 12'h030
`define CAE_CTRL_TYPE_LSB 0
`define CAE_CTRL_SRC_LSB 4
`define CAE_CTRL_LOG_BIT 8
`define CAE_CTRL_ACKTO_BIT 9
`define CAE_NSRC 16
`define CAE_NGRP 12
`define CAE_RST_ACKTO 10'd60
`endif

// ==== verilog/cae_pkg.sv ====
// Purpose: types of the alarm evaluator
// Assumes: nothing
// Notes: type codes are software visible in the control register
package cae_pkg;
    typedef enum logic [2:0] {
        CAE_HI_PROC = 3'h0,
        CAE_LO_PROC = 3'h1,
        CAE_HI_DLY = 3'h2,
        CAE_LO_DLY = 3'h3,
        CAE_HI_RATE = 3'h4,
        CAE_LO_RATE = 3'h5
    } cae_type_t;
    typedef enum logic [2:0] {
        CAE_IDLE = 3'b001,
        CAE_UNACK = 3'b010,
        CAE_ACKED = 3'b100
    } cae_ack_t;
endpackage

// ==== verilog/cae_rate_filter.sv ====
// Purpose: box average of the channel value over a number of whole seconds
// Assumes: tick is a one-cycle pulse per second
// Notes: zero filter time passes the value straight through
`timescale 1ns/10ps
module cae_rate_filter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic [5:0] filt_sec,
    input wire logic signed [15:0] value,
    output logic signed [15:0] avg
);
    import cae_pkg::*;
    logic signed [21:0] acc;
    logic [5:0] cnt;
    wire logic signed [21:0] next_acc = acc + 22'(value);
    wire logic window_end = (cnt + 6'h01) >= filt_sec;

    // RULE8 source averaging: accumulate one sample per second, divide at window end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= 22'h000000;
            cnt <= 6'h00;
            avg <= 16'h0000;
        end else if (clk_en && filt_sec == 6'h00) begin
            avg <= value;
        end else if (clk_en && tick) begin
            if (window_end) begin
                avg <= 16'(next_acc / $signed({16'h0000, filt_sec}));
                acc <= 22'h000000;
                cnt <= 6'h00;
            end else begin
                acc <= next_acc;
                cnt <= cnt + 6'h01;
            end
        end
    end
endmodule

// ==== verilog/cae_alarm.sv ====
// Purpose: one channel alarm: process, delayed and rate alarms with ack timeout and groups
// Assumes: channel value is filtered and synchronous to pclk; sources arrive from pins
// Notes: APB slave, zero wait states, unmapped reads return zero with pslverr
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/10ps
`include "cae_cfg.svh"
module cae_alarm #(
    parameter int TICK_CYC = `CAE_TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] chan_value,
    input wire logic [`CAE_NSRC-1:0] enable_src,
    output logic alarm_state,
    output logic alarm_unack,
    output logic [`CAE_NGRP-1:0] group_out,
    output logic log_valid,
    output logic [1:0] log_entry,
    output logic irq
);
    import cae_pkg::*;

    // configuration registers
    logic [31:0] ctrl;
    logic signed [15:0] trip;
    logic [15:0] hyst;
    logic [15:0] delay_sec;
    logic [15:0] deviation;
    logic [15:0] period_sec;
    logic [5:0] filt_sec;
    logic [9:0] ackto_min;
    logic [`CAE_NGRP-1:0] group_mask;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;

    // state
    logic [`CAE_NSRC-1:0] src_s1, src_s2, src_s3;
    logic [25:0] tick_cnt;
    logic tick;
    logic en_prev;
    logic [15:0] dly_cnt;
    logic cond;
    logic active;
    logic [15:0] per_cnt;
    logic signed [15:0] ref_val;
    logic [15:0] calm_cnt;
    logic [15:0] to_sec;
    cae_ack_t ack_st;
    logic signed [15:0] avg;

    function automatic logic [15:0] abs_diff(input logic signed [15:0] a, input logic signed [15:0] b);
        logic signed [16:0] d;
        d = 17'(a) - 17'(b);
        abs_diff = d[16] ? 16'(-d) : d[15:0];
    endfunction

    // apb decode
    wire logic acc_phase = psel && penable;
    wire logic wr = acc_phase && pwrite && clk_en;
    wire logic rd = acc_phase && !pwrite && clk_en;
    wire logic hit = paddr <= `CAE_OFF_ACK && paddr[1:0] == 2'b00;
    wire logic ack_wr = wr && paddr == `CAE_OFF_ACK && pwdata[0];
    wire cae_type_t atype = cae_type_t'(ctrl[`CAE_CTRL_TYPE_LSB +: 3]);
    // source field stops below the log bit, so enable_src[15] cannot be selected
    wire logic [3:0] src_sel = ctrl[`CAE_CTRL_SRC_LSB +: 4];
    wire logic log_on = ctrl[`CAE_CTRL_LOG_BIT];
    wire logic ackto_on = ctrl[`CAE_CTRL_ACKTO_BIT];

    // RULE9 enable source: zero selects none, always enabled
    // only the selected source must agree, so a toggling neighbour cannot blink the alarm off
    wire logic [3:0] sel_idx = src_sel - 4'h1;
    wire logic src_agree = (src_s2[sel_idx] == src_s3[sel_idx]);
    wire logic sel_lvl = src_s3[sel_idx];
    wire logic enabled = (src_sel == 4'h0) || (sel_lvl && src_agree);
    wire logic en_rise = enabled && !en_prev;

    wire logic is_hi = (atype == CAE_HI_PROC) || (atype == CAE_HI_DLY);
    wire logic is_dly = (atype == CAE_HI_DLY) || (atype == CAE_LO_DLY);
    wire logic is_rate = (atype == CAE_HI_RATE) || (atype == CAE_LO_RATE);
    wire logic signed [16:0] hi_clr = 17'(trip) - 17'($signed({1'b0, hyst}));
    wire logic signed [16:0] lo_clr = 17'(trip) + 17'($signed({1'b0, hyst}));
    // RULE1 trip compare, RULE2 hysteresis band
    wire logic next_cond_hi = cond ? (17'(chan_value) >= hi_clr) : (chan_value > trip);
    wire logic next_cond_lo = cond ? (17'(chan_value) <= lo_clr) : (chan_value < trip);
    wire logic proc_cond = is_hi ? next_cond_hi : next_cond_lo;
    // RULE3 hold off while delay counting
    // the enable edge cycle must not use a count left over from an earlier enable
    wire logic dly_done = !is_dly || (!en_rise && dly_cnt >= delay_sec);
    // RULE5 RULE6 deviation against period start reference
    wire logic [15:0] change = abs_diff(avg, ref_val);
    wire logic fast_trip = change > deviation;
    wire logic period_end = tick && (per_cnt + 16'h0001 >= period_sec);
    wire logic slow_trip = period_end && change < deviation;
    wire logic rate_trip = (atype == CAE_HI_RATE) ? fast_trip : slow_trip;
    wire logic rate_calm = (atype == CAE_HI_RATE) ? (period_end && !fast_trip) : (period_end && !slow_trip);
    // RULE4 delayed alarm reuses ordinary process compare
    wire logic rate_hold = active && !(rate_calm && calm_cnt != 16'h0000);
    wire logic rate_on = rate_trip || rate_hold;
    wire logic proc_on = proc_cond && dly_done;
    wire logic next_active = enabled && (is_rate ? rate_on : proc_on);
    wire logic to_expire = ackto_on && tick && to_sec == 16'h0001;

    cae_rate_filter u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .tick(tick),
        .filt_sec(filt_sec),
        .value(chan_value),
        .avg(avg)
    );

    // three-stage sync of enable sources; seconds timebase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_s1 <= '0;
            src_s2 <= '0;
            src_s3 <= '0;
            tick_cnt <= 26'h0000000;
            tick <= 1'b0;
        end else if (clk_en) begin
            src_s1 <= enable_src;
            src_s2 <= src_s1;
            src_s3 <= src_s2;
            tick <= tick_cnt == 26'(TICK_CYC - 1);
            tick_cnt <= (tick_cnt == 26'(TICK_CYC - 1)) ? 26'h0000000 : tick_cnt + 26'h0000001;
        end
    end

    // config writes; ack timeout clamped to its legal minute range
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h00000000;
            trip <= 16'h0000;
            hyst <= 16'h0000;
            delay_sec <= 16'h0000;
            deviation <= 16'h0000;
            period_sec <= 16'h0001;
            filt_sec <= 6'h00;
            ackto_min <= `CAE_RST_ACKTO;
            group_mask <= '0;
            irq_mask <= 3'h0;
        end else if (wr) begin
            unique case (paddr)
                `CAE_OFF_CTRL: ctrl <= {22'h000000, pwdata[9:0]};
                `CAE_OFF_TRIP: trip <= pwdata[15:0];
                `CAE_OFF_HYST: hyst <= pwdata[15:0];
                `CAE_OFF_DELAY: delay_sec <= pwdata[15:0];
                `CAE_OFF_DEV: deviation <= pwdata[15:0];
                `CAE_OFF_PERIOD: period_sec <= pwdata[15:0];
                `CAE_OFF_FILT: filt_sec <= (pwdata[5:0] > 6'd60) ? 6'd60 : pwdata[5:0];
                // RULE11 timeout minutes 1..999
                `CAE_OFF_ACKTO: ackto_min <= (pwdata[9:0] < `CAE_ACK_MIN_LO) ? `CAE_ACK_MIN_LO :
                                             (pwdata[9:0] > `CAE_ACK_MIN_HI) ? `CAE_ACK_MIN_HI : pwdata[9:0];
                // RULE13 any group combination
                `CAE_OFF_GROUP: group_mask <= pwdata[`CAE_NGRP-1:0];
                `CAE_OFF_IRQ_MASK: irq_mask <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // evaluation state: delay counter restarts on enable rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev <= 1'b0;
            dly_cnt <= 16'h0000;
            cond <= 1'b0;
            active <= 1'b0;
            per_cnt <= 16'h0000;
            ref_val <= 16'h0000;
            calm_cnt <= 16'h0000;
        end else if (clk_en) begin
            en_prev <= enabled;
            cond <= enabled && proc_cond;
            active <= next_active;
            // RULE3 counted from enable turning on
            if (en_rise) begin
                dly_cnt <= 16'h0000;
            end else if (tick && enabled && !dly_done) begin
                dly_cnt <= dly_cnt + 16'h0001;
            end
            // RULE7 new period after trip or at period end
            if (tick && (period_end || (atype == CAE_HI_RATE && fast_trip))) begin
                per_cnt <= 16'h0000;
                ref_val <= avg;
                calm_cnt <= rate_calm ? calm_cnt + 16'h0001 : 16'h0000;
            end else if (tick) begin
                per_cnt <= per_cnt + 16'h0001;
            end
        end
    end

    // ack state machine and timeout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_st <= CAE_IDLE;
            to_sec <= 16'h0000;
        end else if (clk_en) begin
            unique case (ack_st)
                CAE_IDLE: if (next_active) ack_st <= CAE_UNACK;
                CAE_UNACK: if (!next_active) ack_st <= CAE_IDLE;
                    else if (ack_wr) begin
                        ack_st <= CAE_ACKED;
                        to_sec <= 16'(ackto_min * `CAE_SEC_PER_MIN);
                    end
                CAE_ACKED: if (!next_active) ack_st <= CAE_IDLE;
                    // RULE12 re-arm on timeout expiry
                    else if (to_expire) ack_st <= CAE_UNACK;
                    else if (tick && to_sec != 16'h0000) to_sec <= to_sec - 16'h0001;
            endcase
        end
    end

    // outputs, log strobe and interrupt status; set beats read-clear
    wire logic changed = next_active != active;
    wire logic [2:0] ev = {to_expire && ack_st == CAE_ACKED && next_active, changed && !next_active, changed && next_active};
    // status reads show the value after the setup edge, so an event in the setup cycle is not lost to the clear
    wire logic stat_rd = rd && paddr == `CAE_OFF_IRQ_STAT;
    wire logic [2:0] next_stat = (stat_rd ? 3'h0 : irq_stat) | ev;
    wire logic [31:0] rmux = (paddr == `CAE_OFF_CTRL) ? ctrl : (paddr == `CAE_OFF_TRIP) ? 32'(trip) :
        (paddr == `CAE_OFF_HYST) ? 32'(hyst) : (paddr == `CAE_OFF_DELAY) ? 32'(delay_sec) :
        (paddr == `CAE_OFF_DEV) ? 32'(deviation) : (paddr == `CAE_OFF_PERIOD) ? 32'(period_sec) :
        (paddr == `CAE_OFF_FILT) ? 32'(filt_sec) : (paddr == `CAE_OFF_ACKTO) ? 32'(ackto_min) :
        (paddr == `CAE_OFF_GROUP) ? 32'(group_mask) : (paddr == `CAE_OFF_STATE) ? 32'({ack_st == CAE_UNACK, active}) :
        (paddr == `CAE_OFF_IRQ_STAT) ? 32'(next_stat) : (paddr == `CAE_OFF_IRQ_MASK) ? 32'(irq_mask) : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_state <= 1'b0;
            alarm_unack <= 1'b0;
            group_out <= '0;
            log_valid <= 1'b0;
            log_entry <= 2'h0;
            irq_stat <= 3'h0;
            irq <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            alarm_state <= next_active;
            alarm_unack <= next_active && !(ack_st == CAE_ACKED && !to_expire) && !(ack_st == CAE_UNACK && ack_wr);
            // RULE14 group OR of member alarm state
            group_out <= next_active ? group_mask : '0;
            // RULE10 log each state change
            log_valid <= log_on && changed;
            log_entry <= {changed, next_active};
            irq_stat <= next_stat;
            irq <= |(next_stat & irq_mask);
            pready <= psel && !penable;
            prdata <= (psel && !penable && !pwrite && hit) ? rmux : 32'h00000000;
            pslverr <= psel && !penable && !hit;
        end
    end
endmodule

// ==== sim/cae_relay_model.sv ====
// Purpose: far side of the alarm, relay bank and enable source pins
// Assumes: relays pick up one pclk after the group signal
// Notes: only source 1 is driven, the rest stay inactive
`timescale 1ns/10ps
module cae_relay_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_on,
    input wire logic [11:0] group_out,
    output logic [15:0] enable_src,
    output logic [11:0] relay
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) relay <= 12'h000;
        else relay <= group_out;
    end
    assign enable_src = {15'h0000, src_on};
endmodule

// ==== sim/cae_alarm_assertions.sv ====
// Purpose: port relations of the alarm evaluator
// Assumes: one clock domain
// Notes: settings are invisible here, so only setting-free relations
`timescale 1ns/10ps
`include "cae_cfg.svh"
module cae_alarm_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic alarm_state,
    input wire logic alarm_unack,
    input wire logic [`CAE_NGRP-1:0] group_out,
    input wire logic log_valid,
    input wire logic [1:0] log_entry
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero wait state answer
    ready_setup_a: assert property (psel && !penable && clk_en |=> pready) else $error("no ready after setup");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    // unmapped reads answer zero with error
    unmapped_rd_a: assert property (psel && !penable && clk_en && !pwrite && paddr > 12'h030
        |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unack_active_a: assert property (alarm_unack |-> alarm_state) else $error("unack while inactive");
    group_state_a: assert property (!alarm_state |-> group_out == '0) else $error("group without alarm");
    log_entry_a: assert property (log_valid |-> log_entry[1]) else $error("bad log entry");
    ack_clear_a: assert property (psel && penable && pready && pwrite && paddr == 12'h030 && pwdata[0]
        && alarm_unack |=> !alarm_unack) else $error("ack ignored");
    // main scenarios seen
    cover property ($rose(alarm_state));
    cover property (log_valid);
    cover property ($fell(alarm_unack));
endmodule
bind cae_alarm cae_alarm_assertions chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .alarm_state, .alarm_unack, .group_out, .log_valid, .log_entry);

// ==== sim/test_channel_alarm_evaluator.sv ====
// Purpose: self-checking bench of the alarm evaluator
// Assumes: one second is ten cycles here
// Notes: clk_en is dropped once to check that alarm_state freezes
`timescale 1ns/10ps
`include "cae_cfg.svh"
module test_channel_alarm_evaluator;
    import cae_pkg::*;
    typedef struct {cae_type_t t; logic [15:0] v; logic s;} cae_row_t;
    logic pclk, presetn, psel, penable, pwrite, src_on, err, st_q, clk_en;
    logic [11:0] paddr, group_out, relay;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, alarm_state, alarm_unack, log_valid, irq;
    logic signed [15:0] chan_value;
    logic [15:0] enable_src;
    logic [1:0] log_entry;
    int bad_count = 0, compares = 0, log_n = 0, chg_n = 0, log_at = 0;
    cae_row_t rows [8] = '{'{CAE_HI_PROC, 16'd50, 1'b0}, '{CAE_HI_PROC, 16'd101, 1'b1},
        '{CAE_HI_PROC, 16'd95, 1'b1}, '{CAE_HI_PROC, 16'd89, 1'b0}, '{CAE_LO_PROC, 16'd99, 1'b1},
        '{CAE_LO_PROC, 16'd105, 1'b1}, '{CAE_LO_PROC, 16'd111, 1'b0}, '{CAE_LO_PROC, 16'd150, 1'b0}};
    cae_alarm #(.TICK_CYC(10)) dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .chan_value, .enable_src, .alarm_state, .alarm_unack, .group_out,
        .log_valid, .log_entry, .irq);
    cae_relay_model pm (.pclk, .presetn, .src_on, .group_out, .enable_src, .relay);
    // 50 MHz clock
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    // count log pulses and state changes
    always @(posedge pclk) begin
        if (log_valid === 1'b1) log_n++;
        if (alarm_state !== st_q) chg_n++;
        st_q = alarm_state;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // apb master: hold the request until pready is sampled high at a rising edge, take the answer there
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog, the run needs about 1100 cycles
    initial begin
        #200000;
        bad_count++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, chan_value, src_on, st_q} = '0;
        clk_en = 1'b1;
        w(4);
        presetn <= 1;
        apb(0, `CAE_OFF_ACKTO, 0);
        chk(rd, 32'd60);
        apb(0, 12'h034, 0);
        chk({rd[30:0], err}, 32'h1);
        apb(1, `CAE_OFF_TRIP, 32'd100);
        apb(1, `CAE_OFF_HYST, 32'd10);
        apb(1, `CAE_OFF_GROUP, 32'h821);
        $display("reset and map done");
        // table of process cases, irq masked off
        foreach (rows[i]) begin
            apb(1, `CAE_OFF_CTRL, 32'h300 | rows[i].t);
            @(posedge pclk) chan_value <= rows[i].v;
            w(3);
            apb(0, `CAE_OFF_STATE, 0);
            chk(rd[0], rows[i].s);
            chk(group_out, rows[i].s ? 12'h821 : 12'h000);
            chk(irq, 0);
        end
        chk(log_n, 4);
        chk(chg_n, 4);
        $display("table done");
        apb(0, `CAE_OFF_IRQ_STAT, 0);
        apb(1, `CAE_OFF_IRQ_MASK, 32'h1);
        chk(irq, 0);
        @(posedge pclk) chan_value <= 16'd50;
        w(3);
        chk(irq, 1);
        chk(relay, 12'h821);
        apb(0, `CAE_OFF_IRQ_STAT, 0);
        chk(rd[0], 1);
        w(2);
        chk(irq, 0);
        $display("irq done");
        apb(1, `CAE_OFF_ACKTO, 0);
        apb(0, `CAE_OFF_ACKTO, 0);
        chk(rd, 32'd1);
        apb(1, `CAE_OFF_ACKTO, 32'd1000);
        apb(0, `CAE_OFF_ACKTO, 0);
        chk(rd, 32'd999);
        apb(1, `CAE_OFF_ACKTO, 32'd1);
        chk(alarm_unack, 1);
        apb(1, `CAE_OFF_ACK, 32'h1);
        w(2);
        chk(alarm_unack, 0);
        w(500);
        chk(alarm_unack, 0);
        w(200);
        chk(alarm_unack, 1);
        $display("ack timeout done");
        apb(1, `CAE_OFF_DELAY, 32'd2);
        apb(1, `CAE_OFF_CTRL, 32'h312);
        @(posedge pclk) chan_value <= 16'd150;
        w(6);
        chk(alarm_state, 0);
        src_on <= 1;
        w(8);
        chk(alarm_state, 0);
        w(40);
        chk(alarm_state, 1);
        src_on <= 0;
        w(8);
        chk(alarm_state, 0);
        $display("delayed alarm done");
        apb(1, `CAE_OFF_DEV, 32'd5);
        apb(1, `CAE_OFF_FILT, 32'd0);
        apb(1, `CAE_OFF_CTRL, 32'h304);
        w(40);
        chk(alarm_state, 0);
        @(posedge pclk) chan_value <= 16'd180;
        w(4);
        chk(alarm_state, 1);
        w(60);
        chk(alarm_state, 0);
        apb(1, `CAE_OFF_CTRL, 32'h305);
        w(40);
        chk(alarm_state, 1);
        $display("rate alarms done");
        // freeze: nothing moves while clk_en is low; with log off no entry is written
        apb(1, `CAE_OFF_CTRL, 32'h000);
        log_at = log_n;
        @(posedge pclk);
        clk_en <= 0;
        chan_value <= 16'd50;
        w(5);
        chk(alarm_state, 1);
        clk_en <= 1;
        w(3);
        chk(alarm_state, 0);
        chk(log_n, log_at);
        apb(0, `CAE_OFF_IRQ_STAT, 0);
        chk(rd, 32'h7);
        $display("freeze and status done");
        // second reset in mid-run drops outputs and restores register defaults
        apb(1, `CAE_OFF_TRIP, 32'd40);
        w(2);
        chk(alarm_state, 1);
        chk(irq, 1);
        presetn <= 0;
        w(2);
        chk(alarm_state, 0);
        chk(irq, 0);
        presetn <= 1;
        apb(0, `CAE_OFF_TRIP, 0);
        chk(rd, 32'h0);
        apb(0, `CAE_OFF_ACKTO, 0);
        chk(rd, 32'd60);
        $display("mid-run reset done");
        end_of_test;
    end
endmodule
